// ==== rtl/fapc_ecc_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module fapc_ecc_dec (
  fapc_ecc_if.dec e
);
  import fapc_pkg::*;

  for (genvar w = 0; w < 2; w++) begin : g_word
    logic [BUS_W-1:0] d;
    logic [CHK_W-1:0] c;
    logic [SYN_W-1:0] syn;
    logic             par;
    logic [BUS_W-1:0] fix;
    assign d = e.line[w*CWORD_W +: BUS_W];
    assign c = e.line[w*CWORD_W+BUS_W +: CHK_W];
    always_comb begin
      syn = fapc_ecc_syn(d, c);
      par = ^{d, c};
      for (int i = 0; i < BUS_W; i++) begin
        fix[i] = par && (syn == {ECC_MASK[6][i], ECC_MASK[5][i], ECC_MASK[4][i],
                                 ECC_MASK[3][i], ECC_MASK[2][i], ECC_MASK[1][i],
                                 ECC_MASK[0][i]}); // R08
      end
    end
    // Odd parity means one flip, even parity with a syndrome means two
    assign e.data[w*BUS_W +: BUS_W] = d ^ fix; // R08
    assign e.sbe[w] = par; // R08
    assign e.dbe[w] = !par && (syn != '0); // R08
  end
endmodule
`default_nettype wire

// ==== rtl/fapc_ecc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fapc_ecc_if;
  import fapc_pkg::*;
  logic [ARR_W-1:0]  line;
  logic [LINE_W-1:0] data;
  logic [1:0]        sbe;
  logic [1:0]        dbe;
  modport dec (input line, output data, sbe, dbe);
  modport user (output line, input data, sbe, dbe);
endinterface
`default_nettype wire

// ==== rtl/fapc_pkg.sv ====
// Notes on behaviour
// R01: 64-bit bus port, 128-bit array reads.
// R02: Four prefetch buffers, one 128-bit line each.
// R03: Buffer hit answers with zero wait states.
// R04: Miss at 120 MHz inserts three wait states.
// R05: Wait states follow clock: 3/2/1 by frequency.
// R06: Eight check bits per 64-bit word, 144-bit line.
// R07: Writes go out 64 bits wide.
// R08: Correct single-bit, detect double-bit errors.
// R09: Main array split into ten sectors.
// R10: Separate 16 KB test and shadow regions.
// R11: Double-bit error gives bus error, records address.
// R12: Writes and erases invalidate matching buffers.
`default_nettype none
package fapc_pkg;

  localparam int ADDR_W   = 21;
  localparam int BUS_W    = 64;
  localparam int CHK_W    = 8;
  localparam int CWORD_W  = BUS_W + CHK_W;
  localparam int LINE_W   = 2 * BUS_W;
  localparam int ARR_W    = 2 * CWORD_W;
  localparam int LINE_LSB = 4;
  localparam int WORD_LSB = 3;
  localparam int TAG_W    = ADDR_W - LINE_LSB;
  localparam int WADDR_W  = ADDR_W - WORD_LSB;
  localparam int REG_W    = 4;
  localparam int SYN_W    = 7;
  localparam int NBUF_DEF = 4;

  // Clock limits for each wait-state count
  localparam int WS3_MHZ = 120;
  localparam int WS2_MHZ = 80;
  localparam int WS1_MHZ = 60;
  localparam int WS3     = 3;
  localparam int WS2     = 2;
  localparam int WS1     = 1;

  // Region codes: 0..9 main sectors, then test, shadow, unmapped
  localparam logic [REG_W-1:0] REG_MAIN_N = 4'hA;
  localparam logic [REG_W-1:0] REG_TEST   = 4'hA;
  localparam logic [REG_W-1:0] REG_SHADOW = 4'hB;
  localparam logic [REG_W-1:0] REG_NONE   = 4'hF;

  // Sector starts, last entry is the end of the main array
  localparam logic [ADDR_W-1:0] SEC_BASE [0:10] = '{
    21'h000000, 21'h004000, 21'h010000, 21'h01C000, 21'h020000, 21'h030000,
    21'h040000, 21'h060000, 21'h080000, 21'h0C0000, 21'h100000};
  localparam logic [ADDR_W-1:0] TEST_BASE   = 21'h100000;
  localparam logic [ADDR_W-1:0] SHADOW_BASE = 21'h104000;
  localparam logic [ADDR_W-1:0] SHADOW_END  = 21'h108000;

  typedef enum logic [1:0] {
    FAPC_IDLE  = 2'b00,
    FAPC_FETCH = 2'b01
  } fapc_state_t;

  function automatic int fapc_ws(input int mhz);
    if (mhz <= WS1_MHZ) return WS1;
    if (mhz <= WS2_MHZ) return WS2;
    return WS3;
  endfunction

  function automatic logic [REG_W-1:0] fapc_region(input logic [ADDR_W-1:0] a);
    logic [REG_W-1:0] r;
    r = REG_NONE;
    for (int s = 0; s < 10; s++) begin
      if (a >= SEC_BASE[s] && a < SEC_BASE[s+1]) r = REG_W'(s);
    end
    if (a >= TEST_BASE && a < SHADOW_BASE) r = REG_TEST;
    if (a >= SHADOW_BASE && a < SHADOW_END) r = REG_SHADOW;
    return r;
  endfunction

  // Hamming column of each data bit: positions 3..71 skipping powers of two
  function automatic logic [BUS_W-1:0] fapc_ecc_mask(input int k);
    logic [BUS_W-1:0] m;
    logic [6:0]       p;
    int               idx;
    m   = '0;
    idx = 0;
    for (int j = 3; j < CWORD_W; j++) begin
      p = 7'(j);
      if ((p & (p - 7'h01)) != 7'h00) begin
        if (idx < BUS_W) m[idx] = p[k];
        idx++;
      end
    end
    return m;
  endfunction

  localparam logic [BUS_W-1:0] ECC_MASK [0:SYN_W-1] = '{
    fapc_ecc_mask(0), fapc_ecc_mask(1), fapc_ecc_mask(2), fapc_ecc_mask(3),
    fapc_ecc_mask(4), fapc_ecc_mask(5), fapc_ecc_mask(6)};

  function automatic logic [SYN_W-1:0] fapc_ecc_syn(input logic [BUS_W-1:0] d,
                                                     input logic [CHK_W-1:0] c);
    logic [SYN_W-1:0] s;
    for (int k = 0; k < SYN_W; k++) s[k] = c[k] ^ (^(d & ECC_MASK[k]));
    return s;
  endfunction

  function automatic logic [CHK_W-1:0] fapc_ecc_enc(input logic [BUS_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    c[SYN_W-1:0] = fapc_ecc_syn(d, c);
    c[CHK_W-1]   = ^{d, c[SYN_W-1:0]};
    return c;
  endfunction

endpackage
`default_nettype wire

// ==== rtl/fapc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fapc_top #(
  parameter int SYS_CLK_MHZ = 120,
  parameter int NBUF        = fapc_pkg::NBUF_DEF
) (
  // Clock and reset
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_n_i,
  // System bus port
  input  wire logic                           bus_req_i,
  input  wire logic                           bus_we_i,
  input  wire logic [fapc_pkg::ADDR_W-1:0]    bus_addr_i,
  input  wire logic [fapc_pkg::BUS_W-1:0]     bus_wdata_i,
  output logic      [fapc_pkg::BUS_W-1:0]     bus_rdata_o,
  output logic                                bus_ready_o,
  output logic                                bus_err_o,
  output logic                                bus_busy_o,
  // Status
  output logic                                corr_o,
  output logic      [fapc_pkg::ADDR_W-1:0]    fail_addr_o,
  output logic      [fapc_pkg::REG_W-1:0]     sector_o,
  // Erase notification
  input  wire logic                           erase_i,
  input  wire logic [fapc_pkg::REG_W-1:0]     erase_region_i,
  // Flash array
  output logic                                arr_rd_o,
  output logic      [fapc_pkg::TAG_W-1:0]     arr_line_o,
  input  wire logic [fapc_pkg::ARR_W-1:0]     arr_rdata_i,
  output logic                                arr_wr_o,
  output logic      [fapc_pkg::WADDR_W-1:0]   arr_waddr_o,
  output logic      [fapc_pkg::CWORD_W-1:0]   arr_wdata_o
);
  import fapc_pkg::*;

  localparam int VIC_W    = (NBUF > 1) ? $clog2(NBUF) : 1;
  localparam int WAIT_CYC = fapc_ws(SYS_CLK_MHZ); // R05
  localparam logic [1:0] WAIT_LD = 2'(WAIT_CYC);
  localparam logic [1:0] WAIT_LAST = 2'h1;

  if (SYS_CLK_MHZ < 1 || SYS_CLK_MHZ > WS3_MHZ) begin : g_bad_clk
    $error("fapc_top: clock above the fastest wait-state setting");
  end
  if (NBUF < 1 || NBUF > 16 || (NBUF & (NBUF - 1)) != 0) begin : g_bad_nbuf
    $error("fapc_top: buffer count must be a power of two up to 16");
  end

  fapc_state_t          state_r;
  logic [1:0]           wcnt_r;
  logic [ADDR_W-1:0]    pend_addr_r;
  logic                 kill_r;
  logic [NBUF-1:0]      vld_r;
  logic [TAG_W-1:0]     tag_r [NBUF];
  logic [LINE_W-1:0]    dat_r [NBUF];
  logic [1:0]           bad_r [NBUF];
  logic [VIC_W-1:0]     vic_r;
  logic [NBUF-1:0]      hit_v;
  logic [NBUF-1:0]      inv_v;
  logic [VIC_W-1:0]     hit_idx;
  logic                 hit;
  logic                 take;
  logic                 take_rd;
  logic                 take_wr;
  logic                 mapped;
  logic                 miss_start;
  logic                 capture;
  logic                 erase_pend;
  logic                 fill_ok;
  logic [REG_W-1:0]     req_region;
  logic [TAG_W-1:0]     req_tag;
  logic [ADDR_W-1:0]    resp_addr_r;
  logic [3:0]           lat_r;
  logic                 miss_resp_r;
  logic [NBUF-1:0]      hit_v_past;

  fapc_ecc_if ecc ();
  fapc_ecc_dec u_dec (
    .e (ecc.dec)
  );
  assign ecc.line = arr_rdata_i; // R01

  assign req_region = fapc_region(bus_addr_i); // R09 R10
  assign req_tag    = bus_addr_i[ADDR_W-1:LINE_LSB];
  assign mapped     = req_region != REG_NONE;
  // Requests are only taken while idle; a busy master must retry
  assign take       = bus_req_i && state_r == FAPC_IDLE;
  assign take_rd    = take && !bus_we_i && mapped;
  assign take_wr    = take && bus_we_i && mapped;
  assign miss_start = take_rd && !hit;
  assign capture    = state_r == FAPC_FETCH && wcnt_r == WAIT_LAST;
  assign erase_pend = erase_i && fapc_region(pend_addr_r) == erase_region_i;
  assign fill_ok    = !kill_r && !erase_pend; // R12

  for (genvar b = 0; b < NBUF; b++) begin : g_buf
    logic [ADDR_W-1:0] base;
    assign base     = {tag_r[b], {LINE_LSB{1'b0}}};
    assign hit_v[b] = vld_r[b] && tag_r[b] == req_tag; // R03
    assign inv_v[b] = (take_wr && tag_r[b] == req_tag) ||
                      (erase_i && fapc_region(base) == erase_region_i); // R12
  end

  always_comb begin
    hit_idx = '0;
    for (int b = NBUF - 1; b >= 0; b--) begin
      if (hit_v[b]) hit_idx = VIC_W'(b);
    end
  end
  assign hit = |hit_v;

  // Miss sequencing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= FAPC_IDLE;
      wcnt_r      <= '0;
      pend_addr_r <= '0;
      kill_r      <= 1'b0;
    end else begin
      case (state_r)
        FAPC_IDLE: begin
          kill_r <= 1'b0;
          if (miss_start) begin
            state_r     <= FAPC_FETCH;
            wcnt_r      <= WAIT_LD; // R04 R05
            pend_addr_r <= bus_addr_i;
          end
        end
        FAPC_FETCH: begin
          wcnt_r <= wcnt_r - 2'h1;
          if (erase_pend) kill_r <= 1'b1;
          if (capture) state_r <= FAPC_IDLE;
        end
        default: state_r <= FAPC_IDLE;
      endcase
    end
  end

  // Array read strobe stands through the wait states
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arr_rd_o   <= 1'b0;
      arr_line_o <= '0;
      bus_busy_o <= 1'b0;
    end else begin
      if (miss_start) begin
        arr_rd_o   <= 1'b1; // R01
        arr_line_o <= req_tag;
        bus_busy_o <= 1'b1;
      end else if (capture) begin
        arr_rd_o   <= 1'b0;
        bus_busy_o <= 1'b0;
      end
    end
  end

  // Prefetch buffers, round-robin replacement
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vld_r <= '0;
      vic_r <= '0;
      for (int b = 0; b < NBUF; b++) begin
        tag_r[b] <= '0;
        dat_r[b] <= '0;
        bad_r[b] <= '0;
      end
    end else begin
      if (capture) begin
        tag_r[vic_r] <= pend_addr_r[ADDR_W-1:LINE_LSB]; // R02
        dat_r[vic_r] <= ecc.data; // R08
        bad_r[vic_r] <= ecc.dbe;
        vic_r        <= vic_r + VIC_W'(1);
      end
      // Invalidation outranks a fill so stale data never lands
      for (int b = 0; b < NBUF; b++) begin
        if (inv_v[b]) vld_r[b] <= 1'b0; // R12
        else if (capture && vic_r == VIC_W'(b)) vld_r[b] <= fill_ok;
      end
    end
  end

  // Bus answer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_ready_o <= 1'b0;
      bus_err_o   <= 1'b0;
      bus_rdata_o <= '0;
      corr_o      <= 1'b0;
      sector_o    <= REG_NONE;
      fail_addr_o <= '0;
      resp_addr_r <= '0;
      miss_resp_r <= 1'b0;
    end else begin
      bus_ready_o <= 1'b0;
      bus_err_o   <= 1'b0;
      corr_o      <= 1'b0;
      miss_resp_r <= 1'b0;
      if (take && !mapped) begin
        bus_ready_o <= 1'b1;
        bus_err_o   <= 1'b1;
        sector_o    <= REG_NONE;
        resp_addr_r <= bus_addr_i;
      end else if (take_wr) begin
        bus_ready_o <= 1'b1;
        sector_o    <= req_region; // R09 R10
        resp_addr_r <= bus_addr_i;
      end else if (take_rd && hit) begin
        bus_ready_o <= 1'b1; // R03
        bus_rdata_o <= dat_r[hit_idx][bus_addr_i[WORD_LSB]*BUS_W +: BUS_W];
        bus_err_o   <= bad_r[hit_idx][bus_addr_i[WORD_LSB]]; // R11
        sector_o    <= req_region;
        resp_addr_r <= bus_addr_i;
        if (bad_r[hit_idx][bus_addr_i[WORD_LSB]]) fail_addr_o <= bus_addr_i; // R11
      end else if (capture) begin
        bus_ready_o <= 1'b1; // R04
        bus_rdata_o <= ecc.data[pend_addr_r[WORD_LSB]*BUS_W +: BUS_W]; // R01
        bus_err_o   <= ecc.dbe[pend_addr_r[WORD_LSB]]; // R11
        corr_o      <= |ecc.sbe; // R08
        sector_o    <= fapc_region(pend_addr_r);
        resp_addr_r <= pend_addr_r;
        miss_resp_r <= 1'b1;
        if (ecc.dbe[pend_addr_r[WORD_LSB]]) fail_addr_o <= pend_addr_r; // R11
      end
    end
  end

  // Program path: one 64-bit word with its check byte
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arr_wr_o    <= 1'b0;
      arr_waddr_o <= '0;
      arr_wdata_o <= '0;
    end else begin
      arr_wr_o <= take_wr; // R07
      if (take_wr) begin
        arr_waddr_o <= bus_addr_i[ADDR_W-1:WORD_LSB];
        arr_wdata_o <= {fapc_ecc_enc(bus_wdata_i), bus_wdata_i}; // R06 R07
      end
    end
  end

  // Helper: cycles since a miss was taken
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lat_r <= '0;
    else if (miss_start) lat_r <= 4'h1;
    else if (state_r == FAPC_FETCH) lat_r <= lat_r + 4'h1;
  end

  sequence s_hit_req;
    take_rd && hit;
  endsequence
  sequence s_one_cycle_answer;
    ##1 bus_ready_o && !bus_busy_o;
  endsequence

  property p_hit_no_wait;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_hit_req |-> s_one_cycle_answer;
  endproperty
  a_hit_no_wait: assert property (p_hit_no_wait) else $error("hit not answered next cycle"); // R03

  property p_miss_wait;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    miss_resp_r |-> lat_r == 4'(WAIT_CYC + 1);
  endproperty
  a_miss_wait: assert property (p_miss_wait) else $error("miss latency wrong"); // R04 R05

  property p_miss_quiet;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    miss_start |=> !bus_ready_o && arr_rd_o && bus_busy_o;
  endproperty
  a_miss_quiet: assert property (p_miss_quiet) else $error("miss answered early"); // R04

  property p_chk_bits;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    arr_wr_o |-> arr_wdata_o[CWORD_W-1:BUS_W] == fapc_ecc_enc(arr_wdata_o[BUS_W-1:0]);
  endproperty
  a_chk_bits: assert property (p_chk_bits) else $error("check byte wrong"); // R06

  property p_write_out;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    take_wr |=> arr_wr_o && arr_wdata_o[BUS_W-1:0] == $past(bus_wdata_i);
  endproperty
  a_write_out: assert property (p_write_out) else $error("write word not forwarded"); // R07

  property p_clean_pass;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    capture && ecc.sbe == 2'b00 && ecc.dbe == 2'b00 |->
      ecc.data == {arr_rdata_i[CWORD_W +: BUS_W], arr_rdata_i[BUS_W-1:0]};
  endproperty
  a_clean_pass: assert property (p_clean_pass) else $error("clean line altered"); // R08

  property p_dbe_err;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    bus_err_o && bus_ready_o && sector_o != REG_NONE |-> fail_addr_o == resp_addr_r;
  endproperty
  a_dbe_err: assert property (p_dbe_err) else $error("failing address not kept"); // R11

  property p_write_inval;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    take_wr |=> (vld_r & hit_v_past) == '0;
  endproperty
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) hit_v_past <= '0;
    else hit_v_past <= hit_v;
  end
  a_write_inval: assert property (p_write_inval) else $error("stale buffer after write"); // R12

  property p_region;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    bus_ready_o && !bus_err_o |-> sector_o == fapc_region(resp_addr_r) && sector_o != REG_NONE;
  endproperty
  a_region: assert property (p_region) else $error("region decode wrong"); // R09 R10

  property p_fill;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    capture && fill_ok && !inv_v[vic_r] |=> vld_r[$past(vic_r)];
  endproperty
  a_fill: assert property (p_fill) else $error("line not buffered"); // R02

endmodule
`default_nettype wire

// ==== tb/fapc_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fapc_flash_model
  import fapc_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Array read side
  input  wire logic              arr_rd_i,
  input  wire logic [TAG_W-1:0]  arr_line_i,
  input  wire logic [ARR_W-1:0]  flip_i,
  output logic      [ARR_W-1:0]  arr_rdata_o
);
  logic [15:0] junk_r;

  // Content is a pure function of the line, so no storage is needed
  function automatic logic [BUS_W-1:0] pat(input logic [TAG_W-1:0] l, input logic hi);
    return {8'hC3, 7'h00, hi, 31'h00000000, l};
  endfunction

  // Own Hamming coder, written apart from the controller's
  function automatic logic [CHK_W-1:0] enc(input logic [BUS_W-1:0] d);
    logic [CHK_W-1:0] c;
    int               i;
    c = '0;
    i = 0;
    for (int j = 3; j < 72; j++) begin
      if ((j & (j - 1)) != 0) begin
        if (i < 64 && d[i]) c[6:0] ^= 7'(j);
        i++;
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  // Bus idle shows a changing pattern, never the last line
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) junk_r <= 16'h5A3C;
    else junk_r <= junk_r + 16'h9E37;
  end

  always_comb begin
    if (arr_rd_i) begin
      arr_rdata_o = {enc(pat(arr_line_i, 1'b1)), pat(arr_line_i, 1'b1),
                     enc(pat(arr_line_i, 1'b0)), pat(arr_line_i, 1'b0)} ^ flip_i;
    end else begin
      arr_rdata_o = {9{junk_r}};
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_flash_array_prefetch_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_flash_array_prefetch_controller;
  import fapc_pkg::*;
  logic                ref_clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                bus_req_i = 1'b0;
  logic                bus_we_i = 1'b0;
  logic [ADDR_W-1:0]   bus_addr_i = '0;
  logic [BUS_W-1:0]    bus_wdata_i = '0;
  logic [BUS_W-1:0]    bus_rdata_o;
  logic                bus_ready_o;
  logic                bus_err_o;
  logic                bus_busy_o;
  logic                corr_o;
  logic [ADDR_W-1:0]   fail_addr_o;
  logic [REG_W-1:0]    sector_o;
  logic                erase_i = 1'b0;
  logic [REG_W-1:0]    erase_region_i = '0;
  logic                arr_rd_o;
  logic [TAG_W-1:0]    arr_line_o;
  logic [ARR_W-1:0]    arr_rdata_i;
  logic                arr_wr_o;
  logic [WADDR_W-1:0]  arr_waddr_o;
  logic [CWORD_W-1:0]  arr_wdata_o;
  logic [ARR_W-1:0]    flip = '0;
  int                  fail_count = 0;
  int                  compares = 0;
  int                  n;
  int                  nrd;
  int                  n2;
  logic [BUS_W-1:0]    rd;
  logic                er;
  logic                co;
  logic                bz;
  logic                wr;
  logic [WADDR_W-1:0]  wa;
  logic [CWORD_W-1:0]  wdat;
  logic                rdy2;
  logic                rd2;
  logic [TAG_W-1:0]    line2;
  logic [ARR_W-1:0]    rdata2;

  fapc_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
    .bus_we_i(bus_we_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .bus_ready_o(bus_ready_o), .bus_err_o(bus_err_o),
    .bus_busy_o(bus_busy_o), .corr_o(corr_o), .fail_addr_o(fail_addr_o),
    .sector_o(sector_o), .erase_i(erase_i), .erase_region_i(erase_region_i),
    .arr_rd_o(arr_rd_o), .arr_line_o(arr_line_o), .arr_rdata_i(arr_rdata_i),
    .arr_wr_o(arr_wr_o), .arr_waddr_o(arr_waddr_o), .arr_wdata_o(arr_wdata_o));

  fapc_flash_model flash (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .arr_rd_i(arr_rd_o),
    .arr_line_i(arr_line_o), .flip_i(flip), .arr_rdata_o(arr_rdata_i));

  // Second controller set up for a slower clock, sharing the bus stimulus
  fapc_top #(.SYS_CLK_MHZ(WS2_MHZ)) dut_ws2 (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .bus_req_i(bus_req_i), .bus_we_i(bus_we_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(), .bus_ready_o(rdy2), .bus_err_o(),
    .bus_busy_o(), .corr_o(), .fail_addr_o(), .sector_o(), .erase_i(erase_i),
    .erase_region_i(erase_region_i), .arr_rd_o(rd2), .arr_line_o(line2),
    .arr_rdata_i(rdata2), .arr_wr_o(), .arr_waddr_o(), .arr_wdata_o());

  fapc_flash_model flash_ws2 (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .arr_rd_i(rd2),
    .arr_line_i(line2), .flip_i(flip), .arr_rdata_o(rdata2));

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [ARR_W-1:0] seen, input logic [ARR_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One bus transfer; n counts cycles from take to answer
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] wd);
    @(posedge ref_clk_i);
    bus_req_i <= 1'b1;
    bus_we_i <= we;
    bus_addr_i <= a;
    bus_wdata_i <= wd;
    @(posedge ref_clk_i);
    bus_req_i <= 1'b0;
    #1;
    n = 1;
    nrd = 0;
    n2 = 0;
    bz = bus_busy_o;
    wr = arr_wr_o;
    wa = arr_waddr_o;
    wdat = arr_wdata_o;
    while (bus_ready_o !== 1'b1 && n < 20) begin
      if (rdy2 === 1'b1 && n2 == 0) n2 = n;
      if (arr_rd_o === 1'b1) nrd++;
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (rdy2 === 1'b1 && n2 == 0) n2 = n;
    rd = bus_rdata_o;
    er = bus_err_o;
    co = corr_o;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input int exp_n, input logic e);
    bus(1'b0, a, '0);
    chk(ARR_W'(n), ARR_W'(exp_n));
    chk(ARR_W'(n2), ARR_W'(exp_n == 1 ? 1 : WS2 + 1));
    chk(ARR_W'(er), ARR_W'(e));
    if (!e) chk(ARR_W'(rd), ARR_W'(flash.pat(a[ADDR_W-1:LINE_LSB], a[3])));
  endtask

  task automatic erase(input logic [REG_W-1:0] r);
    @(posedge ref_clk_i);
    erase_i <= 1'b1;
    erase_region_i <= r;
    @(posedge ref_clk_i);
    erase_i <= 1'b0;
  endtask

  task automatic t_reset();
    chk(ARR_W'({bus_ready_o, bus_err_o, bus_busy_o, arr_rd_o, arr_wr_o, corr_o}), '0);
    chk(ARR_W'(sector_o), ARR_W'(REG_NONE));
    $display("test reset done");
  endtask

  task automatic t_miss_hit();
    rd_chk(21'h000100, 4, 1'b0);
    chk(ARR_W'(nrd), ARR_W'(3));
    chk(ARR_W'(bz), ARR_W'(1));
    rd_chk(21'h000108, 1, 1'b0);
    chk(ARR_W'({bz, nrd[0]}), '0);
    $display("test miss_hit done");
  endtask

  task automatic t_bufs();
    for (int i = 0; i < 4; i++) rd_chk(21'h008000 + 21'(i * 16), 4, 1'b0);
    for (int i = 3; i >= 0; i--) rd_chk(21'h008008 + 21'(i * 16), 1, 1'b0);
    $display("test buffers done");
  endtask

  task automatic t_sectors();
    int               kb [10];
    logic [ADDR_W-1:0] b;
    kb = '{16, 48, 48, 16, 64, 64, 128, 128, 256, 256};
    b = '0;
    for (int s = 0; s < 10; s++) begin
      rd_chk(b, 4, 1'b0);
      chk(ARR_W'(sector_o), ARR_W'(s));
      b = b + 21'(kb[s] * 1024);
      rd_chk(b - 21'h8, 4, 1'b0);
      chk(ARR_W'(sector_o), ARR_W'(s));
    end
    chk(ARR_W'(b), ARR_W'(21'h100000));
    rd_chk(21'h100000, 4, 1'b0);
    chk(ARR_W'(sector_o), ARR_W'(4'hA));
    rd_chk(21'h103FF8, 4, 1'b0);
    chk(ARR_W'(sector_o), ARR_W'(4'hA));
    rd_chk(21'h104000, 4, 1'b0);
    chk(ARR_W'(sector_o), ARR_W'(4'hB));
    rd_chk(21'h107FF8, 4, 1'b0);
    chk(ARR_W'(sector_o), ARR_W'(4'hB));
    rd_chk(21'h108000, 1, 1'b1);
    chk(ARR_W'({sector_o, nrd[0]}), ARR_W'(5'h1E));
    $display("test sectors done");
  endtask

  task automatic t_ecc();
    @(posedge ref_clk_i) flip <= ARR_W'(1) << 5;
    rd_chk(21'h022000, 4, 1'b0);
    chk(ARR_W'(co), ARR_W'(1));
    @(posedge ref_clk_i) flip <= ARR_W'(1) << 64;
    rd_chk(21'h022010, 4, 1'b0);
    chk(ARR_W'(co), ARR_W'(1));
    @(posedge ref_clk_i) flip <= (ARR_W'(1) << 77) | (ARR_W'(1) << 81);
    rd_chk(21'h022020, 4, 1'b0);
    rd_chk(21'h022028, 1, 1'b1);
    chk(ARR_W'(fail_addr_o), ARR_W'(21'h022028));
    @(posedge ref_clk_i) flip <= (ARR_W'(1) << 3) | (ARR_W'(1) << 7);
    rd_chk(21'h022030, 4, 1'b1);
    chk(ARR_W'(fail_addr_o), ARR_W'(21'h022030));
    @(posedge ref_clk_i) flip <= '0;
    $display("test ecc done");
  endtask

  task automatic t_write();
    logic [BUS_W-1:0] wd;
    wd = 64'h0123456789ABCDEF;
    rd_chk(21'h032000, 4, 1'b0);
    bus(1'b1, 21'h032008, wd);
    chk(ARR_W'({n[1:0], wr}), ARR_W'(3'b011));
    chk(ARR_W'(wa), ARR_W'(18'h06401));
    chk(ARR_W'(wdat), ARR_W'({flash.enc(wd), wd}));
    rd_chk(21'h032000, 4, 1'b0);
    $display("test write done");
  endtask

  task automatic t_erase();
    rd_chk(21'h042000, 4, 1'b0);
    erase(4'h5);
    rd_chk(21'h042008, 1, 1'b0);
    erase(4'h6);
    rd_chk(21'h042000, 4, 1'b0);
    $display("test erase done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    t_reset();
    rst_n_i <= 1'b1;
    t_miss_hit();
    t_bufs();
    t_sectors();
    t_ecc();
    t_write();
    t_erase();
    end_sim();
  end

  // Whole run needs a few hundred cycles at most
  initial begin
    #80000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
